// ### hdl/pee_ctrl.v
// Purpose: host controller driving a byte-wide parallel memory
// Assumes: memory pins synchronous to pclk, APB register port
// Notes:   one bus cycle per command, three for PREFIX; software orders the sequence
// Notes on behaviour
// - Write: strobe low with chip select low, output drive high.
// - Page holds up to 64 bytes programmed together.
// - Next page byte loaded within 150 us window.
// - Same page address held for each load of a page.
// - Three-byte sequence sets lock after programming time.
// - Sequence: AA to 5555, 55 to 2AAA, A0 to 5555.
// - Locked writes preceded by the same three-byte sequence.
// - Command bytes follow page timing and are not stored.
// - Chip erase by software code or elevated output drive; only the elevated drive (PEE_CMD_HWERASE) is built here.
//
// Design decisions made here: the APB register port and the register addresses.
`include "pee_map.vh"
`timescale 1ns/100ps
`default_nettype none
module pee_ctrl #(
  parameter TWC_CYC  = `PEE_TWC_CYC,
  parameter BYTE_LOAD_WINDOW_CYC = `PEE_BYTE_LOAD_WINDOW_CYC
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Memory pins
  output reg  [14:0] mem_addr,
  output reg         chip_select_n,
  output reg         output_drive_n,
  output reg         write_strobe_n,
  input  wire [7:0]  mem_data_in,
  output reg  [7:0]  mem_data_out,
  output reg         mem_data_oe,
  output reg         id_access_pin,
  output reg         erase_drive_hv
);
  localparam S_IDLE = 6'b000001;
  localparam S_RDLO = 6'b000010;
  localparam S_WRLO = 6'b000100;
  localparam S_WRHI = 6'b001000;
  localparam S_PREF = 6'b010000;
  localparam S_WAIT = 6'b100000;

  reg [5:0]  st_r;
  reg [14:0] addr_r;
  reg [7:0]  wdata_r;
  reg [7:0]  rdata_r;
  reg [7:0]  prev_r;
  reg        id_r;
  reg        erase_r;
  reg        busy_r;
  reg        done_r;
  reg        tmo_r;
  reg        err_r;
  reg        win_r;
  reg [1:0]  pidx_r;
  reg        seen_r;
  reg        tload;
  reg [23:0] tval;
  reg        wload;
  wire       tzero;
  wire       wzero;
  wire       acc;
  wire       wr;
  wire [2:0] cmd;

  assign acc = psel & penable & ~pready;
  assign wr  = acc & pwrite;
  assign cmd = pwdata[`PEE_CMD_LSB +: `PEE_CMD_W];

  function [23:0] cyc;
    input integer n;
    begin
      cyc = n[23:0];
    end
  endfunction

  function [14:0] seq_addr;
    input [1:0] i;
    begin
      seq_addr = (i == 2'd1) ? `PEE_SEQ_A1 : `PEE_SEQ_A0;
    end
  endfunction

  function [7:0] seq_data;
    input [1:0] i;
    begin
      case (i)
        2'd0:    seq_data = `PEE_SEQ_D0;
        2'd1:    seq_data = `PEE_SEQ_D1;
        default: seq_data = `PEE_SEQ_D2;
      endcase
    end
  endfunction

  // Strobe width timer
  pee_timer #(.W(24)) u_strobe (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tload),
    .value   (tval),
    .zero    (tzero)
  );

  // Byte load window
  pee_timer #(.W(24)) u_window (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (wload),
    .value   (cyc(BYTE_LOAD_WINDOW_CYC)),
    .zero    (wzero)
  );

  // ----------------------------------------------------------------
  // Pin sequencer
  // ----------------------------------------------------------------
  always @* begin
    tload = 1'b0;
    tval  = 24'h000000;
    wload = 1'b0;
    case (st_r)
      S_IDLE: begin
        if (wr && paddr == `PEE_OFF_CTRL && cmd != `PEE_CMD_NONE) begin
          tload = 1'b1;
          tval  = (cmd == `PEE_CMD_HWERASE) ? cyc(TWC_CYC) :
                  (cmd == `PEE_CMD_READ || cmd == `PEE_CMD_POLL) ?
                  cyc(`PEE_TACC_CYC) : cyc(`PEE_TWP_CYC);
        end
      end
      S_WRLO: begin
        if (tzero) begin
          tload = 1'b1;
          tval  = cyc(`PEE_TWPH_CYC);
          wload = 1'b1;
        end
      end
      S_WRHI: begin
        if (tzero && pidx_r != 2'd0 && pidx_r != 2'd3) begin
          tload = 1'b1;
          tval  = cyc(`PEE_TWP_CYC);
        end
      end
      default: tload = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= S_IDLE;
      chip_select_n <= 1'b1;
      output_drive_n <= 1'b1;
      write_strobe_n <= 1'b1;
      mem_addr <= 15'h0000;
      mem_data_out <= 8'h00;
      mem_data_oe <= 1'b0;
      id_access_pin <= 1'b0;
      erase_drive_hv <= 1'b0;
      rdata_r <= 8'h00;
      prev_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      tmo_r <= 1'b0;
      err_r <= 1'b0;
      win_r <= 1'b0;
      pidx_r <= 2'd0;
      seen_r <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      addr_r <= 15'h0000;
      wdata_r <= 8'h00;
      id_r <= 1'b0;
      erase_r <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (win_r && wzero) begin
        win_r <= 1'b0;
        tmo_r <= 1'b1;
      end
      case (st_r)
        S_IDLE: begin
          if (acc && !pwrite) begin
            pready <= 1'b1;
            case (paddr)
              `PEE_OFF_CTRL:   prdata <= {26'h0, erase_r, id_r, 4'h0};
              `PEE_OFF_ADDR:   prdata <= {17'h0, addr_r};
              `PEE_OFF_WDATA:  prdata <= {24'h0, wdata_r};
              `PEE_OFF_STATUS: prdata <= {28'h0, err_r, tmo_r,
                                          done_r, busy_r};
              `PEE_OFF_RDATA:  prdata <= {24'h0, rdata_r};
              default: begin
                prdata  <= 32'h00000000;
                pslverr <= 1'b1;
              end
            endcase
          end else if (wr) begin
            case (paddr)
              `PEE_OFF_ADDR:  addr_r <= pwdata[14:0];
              `PEE_OFF_WDATA: wdata_r <= pwdata[7:0];
              `PEE_OFF_CTRL: begin
                id_r    <= pwdata[`PEE_ID_BIT];
                id_access_pin <= pwdata[`PEE_ID_BIT];
                erase_r <= pwdata[`PEE_ERASE_BIT];
              end
              default: pslverr <= 1'b1;
            endcase
            if (paddr != `PEE_OFF_CTRL || cmd == `PEE_CMD_NONE)
              pready <= 1'b1;
            else begin
              done_r <= 1'b0;
              mem_addr <= addr_r;
              case (cmd)
                `PEE_CMD_READ, `PEE_CMD_POLL: begin
                  chip_select_n  <= 1'b0;
                  output_drive_n <= 1'b0;
                  st_r <= S_RDLO;
                end
                `PEE_CMD_PREFIX: begin
                  mem_addr <= seq_addr(2'd0);
                  mem_data_out <= seq_data(2'd0);
                  mem_data_oe <= 1'b1;
                  chip_select_n  <= 1'b0;
                  write_strobe_n <= 1'b0;
                  pidx_r <= 2'd1;
                  st_r <= S_WRLO;
                end
                `PEE_CMD_HWERASE: begin
                  chip_select_n  <= 1'b0;
                  write_strobe_n <= 1'b0;
                  erase_drive_hv <= 1'b1;
                  st_r <= S_WAIT;
                end
                `PEE_CMD_LOAD: begin
                  mem_data_out <= wdata_r;
                  mem_data_oe <= 1'b1;
                  chip_select_n  <= 1'b0;
                  write_strobe_n <= 1'b0;
                  pidx_r <= 2'd0;
                  st_r <= S_WRLO;
                end
                default: begin
                  err_r <= 1'b1;
                  pready <= 1'b1;
                end
              endcase
            end
          end
        end
        S_RDLO: begin
          if (tzero) begin
            rdata_r <= mem_data_in;
            prev_r  <= mem_data_in;
            // Done once toggle stops; locked writes store no data
            if (busy_r && seen_r && mem_data_in[6] == prev_r[6]) begin
              busy_r <= 1'b0;
              done_r <= 1'b1;
            end
            seen_r <= 1'b1;
            chip_select_n  <= 1'b1;
            output_drive_n <= 1'b1;
            pready <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        S_WRLO: begin
          // Pulse held well past 15 ns
          if (tzero) begin
            write_strobe_n <= 1'b1;
            chip_select_n  <= 1'b1;
            win_r <= 1'b1;
            tmo_r <= win_r & wzero;
            busy_r <= 1'b1;
            seen_r <= 1'b0;
            st_r <= S_WRHI;
          end
        end
        S_WRHI: begin
          if (tzero) begin
            mem_data_oe <= 1'b0;
            if (pidx_r != 2'd0 && pidx_r != 2'd3) begin
              mem_addr <= seq_addr(pidx_r);
              mem_data_out <= seq_data(pidx_r);
              mem_data_oe <= 1'b1;
              chip_select_n  <= 1'b0;
              write_strobe_n <= 1'b0;
              pidx_r <= pidx_r + 2'd1;
              st_r <= S_WRLO;
            end else begin
              pidx_r <= 2'd0;
              pready <= 1'b1;
              st_r <= S_IDLE;
            end
          end
        end
        S_WAIT: begin
          if (tzero) begin
            chip_select_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            erase_drive_hv <= 1'b0;
            done_r <= 1'b1;
            pready <= 1'b1;
            st_r <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### hdl/pee_map.vh
// Purpose: constants for the parallel memory access controller
// Assumes: 100 MHz pclk, APB register port
// Notes:   offsets are byte addresses of 32-bit words
`ifndef PEE_MAP_VH
`define PEE_MAP_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PEE_OFF_CTRL    12'h000
`define PEE_OFF_ADDR    12'h004
`define PEE_OFF_WDATA   12'h008
`define PEE_OFF_STATUS  12'h00C
`define PEE_OFF_RDATA   12'h010
// ----------------------------------------------------------------
// Control fields and commands
// ----------------------------------------------------------------
`define PEE_CMD_LSB     0
`define PEE_CMD_W       3
`define PEE_ID_BIT      4
`define PEE_ERASE_BIT   5
`define PEE_CMD_NONE    3'h0
`define PEE_CMD_READ    3'h1
`define PEE_CMD_LOAD    3'h2
`define PEE_CMD_POLL    3'h3
`define PEE_CMD_PREFIX  3'h4
`define PEE_CMD_HWERASE 3'h5
// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define PEE_ST_BUSY     0
`define PEE_ST_DONE     1
`define PEE_ST_TMO      2
`define PEE_ST_ERR      3
// ----------------------------------------------------------------
// Protection command bytes and addresses
// ----------------------------------------------------------------
`define PEE_SEQ_A0      15'h5555
`define PEE_SEQ_A1      15'h2AAA
`define PEE_SEQ_D0      8'hAA
`define PEE_SEQ_D1      8'h55
`define PEE_SEQ_D2      8'hA0
// ----------------------------------------------------------------
// Timing in ns and us, derived cycles at 10 ns, programming time in cycles
// ----------------------------------------------------------------
`define PEE_CLK_NS      10
`define PEE_TWP_NS      100
`define PEE_TWPH_NS     50
`define PEE_TACC_NS     70
`define PEE_BYTE_LOAD_WINDOW_US     150
`define PEE_TWP_CYC     ((`PEE_TWP_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_TWPH_CYC    ((`PEE_TWPH_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_TACC_CYC    ((`PEE_TACC_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS + 1)
`define PEE_BYTE_LOAD_WINDOW_CYC    ((`PEE_BYTE_LOAD_WINDOW_US * 1000) / `PEE_CLK_NS)
`define PEE_TWC_CYC     1000000
`endif

// ### hdl/pee_timer.v
// Purpose: down counter for strobe widths and load windows
// Assumes: load has priority over counting
// Notes:   zero flag is registered
`timescale 1ns/100ps
`default_nettype none
module pee_timer #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Control
  input  wire         load,
  input  wire [W-1:0] value,
  // Status
  output reg          zero
);
  reg [W-1:0] cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {W{1'b0}};
      zero  <= 1'b1;
    end else if (load) begin
      cnt_r <= value;
      zero  <= (value == {W{1'b0}});
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      zero  <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule
`default_nettype wire

// ### sim/pee_ctrl_assertions.sv
// Purpose: pin-level checks on the memory controller
// Assumes: pins change only on pclk
// Notes:   bound to every instance of the controller
`timescale 1ns/100ps
`default_nettype none
module pee_ctrl_assertions #(
  parameter TWC_CYC  = 50,
  parameter BYTE_LOAD_WINDOW_CYC = 40
) (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Memory pins
  input wire logic [14:0] mem_addr,
  input wire logic        chip_select_n,
  input wire logic        output_drive_n,
  input wire logic        write_strobe_n,
  input wire logic [7:0]  mem_data_out,
  input wire logic        mem_data_oe,
  input wire logic        id_access_pin,
  input wire logic        erase_drive_hv
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  drv_float_a: assert property (mem_data_oe |-> output_drive_n)
    else $error("data driven while output drive low");
  read_mode_a: assert property (!output_drive_n && !chip_select_n
    |-> write_strobe_n && !mem_data_oe) else $error("bad read pins");
  wr_drive_a: assert property (!write_strobe_n && !chip_select_n
    && !erase_drive_hv |-> output_drive_n && mem_data_oe)
    else $error("write without data or with output drive");
  // Keeps well clear of the noise filter width
  wr_width_a: assert property ($fell(write_strobe_n)
    |-> !write_strobe_n [*8]) else $error("write pulse too short");
  addr_hold_a: assert property (!write_strobe_n && !chip_select_n
    && $past(!write_strobe_n && !chip_select_n) |-> $stable(mem_addr))
    else $error("address moved during write");
  data_hold_a: assert property ($rose(write_strobe_n)
    && !$past(erase_drive_hv) |-> $stable(mem_data_out)
    && $past(mem_data_oe)) else $error("data not held at strobe rise");
  erase_hiz_a: assert property (erase_drive_hv |-> !mem_data_oe)
    else $error("data driven during erase");
  id_stable_a: assert property (!chip_select_n
    && $past(!chip_select_n) |-> $stable(id_access_pin))
    else $error("id pin moved during access");
endmodule
bind pee_ctrl pee_ctrl_assertions #(.TWC_CYC(TWC_CYC), .BYTE_LOAD_WINDOW_CYC(BYTE_LOAD_WINDOW_CYC))
  i_pee_ctrl_assertions (.pclk(pclk), .presetn(presetn),
  .mem_addr(mem_addr), .chip_select_n(chip_select_n),
  .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
  .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe),
  .id_access_pin(id_access_pin), .erase_drive_hv(erase_drive_hv));
`default_nettype wire

// ### sim/pee_mem_model.sv
// Purpose: byte-wide nonvolatile memory model
// Assumes: pins sampled on pclk; erased cells read FF
// Notes:   no disable sequence, so the lock never clears
`timescale 1ns/100ps
`default_nettype none
module pee_mem_model #(
  parameter TWC  = 50,
  parameter BYTE_LOAD_WINDOW = 40
) (
  // Clock
  input  wire logic        pclk,
  // Device pins
  input  wire logic [14:0] mem_addr,
  input  wire logic        chip_select_n,
  input  wire logic        output_drive_n,
  input  wire logic        write_strobe_n,
  input  wire logic [7:0]  mem_data_in,
  input  wire logic        id_access_pin,
  input  wire logic        erase_drive_hv,
  output var  logic [7:0]  dev_dout
);
  logic [7:0]  mem_r [0:32767];
  logic [7:0]  idm_r [0:63];
  logic [7:0]  pbuf_r [0:63];
  logic [63:0] pmask_r = '0;
  logic [14:0] la_r;
  logic [7:0]  last_r = 8'h00;
  logic        wel_r = 0, rdl_r = 0, tog_r = 0, idw_r = 0, era_r = 0;
  logic        arm_r = 0;
  int          win_r = 0, busy_r = 0, seq_r = 0;
  logic        lock_r = 1'b0;
  // write only with output drive high
  wire wr = !chip_select_n && !write_strobe_n && output_drive_n
            && !erase_drive_hv;
  wire rd = !chip_select_n && !output_drive_n && write_strobe_n;
  wire er = erase_drive_hv && !chip_select_n && !write_strobe_n;
  function automatic logic hit(int i, logic [14:0] a, logic [7:0] d);
    return a == (i == 1 ? 15'h2AAA : 15'h5555)
           && d == (i == 0 ? 8'hAA : i == 1 ? 8'h55 : 8'hA0);
  endfunction
  initial begin
    for (int i = 0; i < 32768; i++) mem_r[i] = 8'hFF;
    for (int i = 0; i < 64; i++) idm_r[i] = 8'hFF;
    dev_dout = 8'h00;
  end
  always @(posedge pclk) begin
    if (wr && !wel_r) begin
      la_r = mem_addr;
      idw_r = id_access_pin;
    end
    if (!wr && wel_r && busy_r == 0) begin
      if (seq_r < 3 && hit(seq_r, la_r, mem_data_in)) seq_r++;
      else begin
        pbuf_r[la_r[5:0]] = mem_data_in;
        pmask_r[la_r[5:0]] = 1'b1;
        last_r = mem_data_in;
      end
      win_r = BYTE_LOAD_WINDOW;
    end
    wel_r = wr;
    if (win_r == 1) begin
      arm_r = seq_r == 3;
      for (int i = 0; i < 64; i++)
        if (pmask_r[i] && (!lock_r || arm_r)) begin
          if (idw_r && la_r[14:6] == 9'h1FF) idm_r[i] = pbuf_r[i];
          else mem_r[{la_r[14:6], i[5:0]}] = pbuf_r[i];
        end
      pmask_r = '0;
      seq_r = 0;
      busy_r = TWC;
    end
    if (win_r > 0) win_r--;
    // lock set at end of programming
    if (busy_r == 1 && arm_r) lock_r = 1'b1;
    if (busy_r > 0) busy_r--;
    if (rd && !rdl_r) begin
      if (win_r > 0 || busy_r > 0) begin
        dev_dout <= {~last_r[7], tog_r, last_r[5:0]};
        tog_r = ~tog_r;
      end else if (id_access_pin && mem_addr >= 15'h7FC0)
        dev_dout <= idm_r[mem_addr[5:0]];
      else dev_dout <= mem_r[mem_addr];
    end
    // released lines must not keep the old byte
    if (!rd && rdl_r) dev_dout <= ~dev_dout;
    rdl_r = rd;
    if (er && !era_r) for (int i = 0; i < 32768; i++) mem_r[i] = 8'hFF;
    era_r = er;
  end
endmodule
`default_nettype wire

// ### sim/pee_ctrl_tb.sv
// Purpose: self-checking bench for the memory controller
// Assumes: short programming and window counts
// Notes:   each scenario leaves the device idle
`include "pee_map.vh"
`timescale 1ns/100ps
`default_nettype none
module pee_ctrl_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [14:0] mem_addr;
  logic        chip_select_n, output_drive_n, write_strobe_n;
  logic [7:0]  mem_data_out, dev_dout;
  logic        mem_data_oe, id_access_pin, erase_drive_hv;
  wire  [7:0]  mem_data_in = mem_data_oe ? mem_data_out : dev_dout;
  int          n_fail = 0, checked = 0;
  pee_ctrl #(.TWC_CYC(50), .BYTE_LOAD_WINDOW_CYC(40)) i_pee_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_addr, .chip_select_n, .output_drive_n,
    .write_strobe_n, .mem_data_in, .mem_data_out, .mem_data_oe,
    .id_access_pin, .erase_drive_hv);
  pee_mem_model #(.TWC(50), .BYTE_LOAD_WINDOW(40)) i_pee_mem_model (
    .pclk, .mem_addr, .chip_select_n, .output_drive_n, .write_strobe_n,
    .mem_data_in, .id_access_pin, .erase_drive_hv, .dev_dout);
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 3000);
    if (pready !== 1'b1) n_fail++;
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ctl(input logic [2:0] c, input logic id);
    apb(1'b1, `PEE_OFF_CTRL, {27'h0, id, 1'b0, c});
  endtask
  task automatic memw(input logic [14:0] a, input logic [7:0] d,
                      input logic id);
    apb(1'b1, `PEE_OFF_ADDR, {17'h0, a});
    apb(1'b1, `PEE_OFF_WDATA, {24'h0, d});
    ctl(`PEE_CMD_LOAD, id);
  endtask
  task automatic memr(input logic [14:0] a, input logic id);
    apb(1'b1, `PEE_OFF_ADDR, {17'h0, a});
    ctl(`PEE_CMD_READ, id);
    apb(1'b0, `PEE_OFF_RDATA, 32'h0);
  endtask
  task automatic poll(input logic id);
    ctl(`PEE_CMD_POLL, id);
    apb(1'b0, `PEE_OFF_RDATA, 32'h0);
  endtask
  task automatic wait_done(input logic id);
    int n;
    n = 0;
    do begin
      poll(id);
      apb(1'b0, `PEE_OFF_STATUS, 32'h0);
      n++;
    end while (rv[`PEE_ST_BUSY] !== 1'b0 && n < 100);
    chk({rv[`PEE_ST_DONE], rv[`PEE_ST_BUSY]}, 2'h2);
  endtask
  task automatic t_byte();
    logic b6;
    memw(15'h0123, 8'h5A, 1'b0);
    poll(1'b0);
    chk(rv[7], 1'b1);
    b6 = rv[6];
    poll(1'b0);
    chk(rv[6], {31'h0, ~b6});
    wait_done(1'b0);
    chk(rv[`PEE_ST_TMO], 1'b1);
    memr(15'h0123, 1'b0);
    chk(rv[7:0], 8'h5A);
    $display("test byte done");
  endtask
  task automatic t_page();
    memw(15'h0245, 8'h11, 1'b0);
    memw(15'h0241, 8'h22, 1'b0);
    memw(15'h0241, 8'h33, 1'b0);
    wait_done(1'b0);
    memr(15'h0245, 1'b0);
    chk(rv[7:0], 8'h11);
    memr(15'h0241, 1'b0);
    chk(rv[7:0], 8'h33);
    memr(15'h0242, 1'b0);
    chk(rv[7:0], 8'hFF);
    $display("test page done");
  endtask
  task automatic t_id();
    memw(15'h7FC1, 8'h3C, 1'b1);
    wait_done(1'b1);
    memr(15'h7FC1, 1'b1);
    chk(rv[7:0], 8'h3C);
    memr(15'h7FC1, 1'b0);
    chk(rv[7:0], 8'hFF);
    $display("test id done");
  endtask
  task automatic t_erase();
    ctl(`PEE_CMD_HWERASE, 1'b0);
    memr(15'h0245, 1'b0);
    chk(rv[7:0], 8'hFF);
    $display("test erase done");
  endtask
  task automatic t_lock();
    ctl(`PEE_CMD_PREFIX, 1'b0);
    wait_done(1'b0);
    memw(15'h0300, 8'h77, 1'b0);
    wait_done(1'b0);
    memr(15'h0300, 1'b0);
    chk(rv[7:0], 8'hFF);
    ctl(`PEE_CMD_PREFIX, 1'b0);
    memw(15'h0300, 8'h66, 1'b0);
    wait_done(1'b0);
    memr(15'h0300, 1'b0);
    chk(rv[7:0], 8'h66);
    memr(15'h5555, 1'b0);
    chk(rv[7:0], 8'hFF);
    $display("test lock done");
  endtask
  task automatic t_refuse();
    apb(1'b0, 12'h040, 32'h0);
    chk(ev, 1'b1);
    ctl(3'h6, 1'b0);
    apb(1'b0, `PEE_OFF_STATUS, 32'h0);
    chk(rv[`PEE_ST_ERR], 1'b1);
    $display("test refuse done");
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #300000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_byte();
    t_page();
    t_id();
    t_erase();
    t_lock();
    t_refuse();
    end_of_test();
  end
endmodule
`default_nettype wire
